/* core/ppd_regs.sv */
// Spare pin pair, video/audio data path control and strap status bank.
// Assumes an Avalon-MM master with byte addresses and one clock at 20 MHz.
`timescale 1ns/1ps

// How it works
// - A spare pin in output mode drives its output-value bit; reset leaves it undriven with output low.
// - Two-bit mode per pin: 00 functional in, 10 high-z, 01 output, 11 input.
// - Bypass bit 6 forwards pixels regardless of active flag and blocks packet audio.
// - Bit 5 sets active-flag polarity: 0 active high, 1 active low.
// - Bit 4 picks I2S source: pass through from video pins, or regenerate.
// - Bit 3 set makes bit 0 the second channel enable, no detector override.
// - Bit 2 selects colour depth: 0 is 24-bit, 1 is 18-bit.
// - Bit 1 selects audio transport: data islands or forward-channel frame.
// - Bit 0 enables the second I2S channel; in-band detection may override.
// - Strap status bit 7 reads 1 once strap B is settled and latched.
// - Strap status bits 6:4 return strap B decoded level.
// - Strap status bit 3 reads 1 once strap A is settled and latched.
// - Strap status bits 2:0 return strap A decoded level.
module ppd_regs #(
   parameter int PIX_W      = 24,
   parameter int SETTLE_CYC = ppd_pkg::STRAP_SETTLE_CYC
) (
   input  wire logic                               clk_i,
   input  wire logic                               nrst_i,
   // Avalon-MM slave
   input  wire logic [ppd_pkg::ADDR_W-1:0]         avs_address_i,
   input  wire logic                               avs_read_i,
   input  wire logic                               avs_write_i,
   input  wire logic [ppd_pkg::DATA_W-1:0]         avs_writedata_i,
   input  wire logic [3:0]                         avs_byteenable_i,
   output logic      [ppd_pkg::DATA_W-1:0]         avs_readdata_o,
   output logic      [1:0]                         avs_response_o,
   output logic                                    avs_waitrequest_o,
   // Spare pins
   input  wire logic                               spare_io_seven_i,
   output logic                                    spare_io_seven_o,
   output logic                                    spare_io_seven_oe_n_o,
   output logic                                    spare_io_seven_func_o,
   input  wire logic                               spare_io_eight_i,
   output logic                                    spare_io_eight_o,
   output logic                                    spare_io_eight_oe_n_o,
   output logic                                    spare_io_eight_func_o,
   // Video path
   input  wire logic [PIX_W-1:0]                   rgb_i,
   input  wire logic                               video_active_flag_i,
   output logic      [PIX_W-1:0]                   rgb_o,
   output logic                                    pixel_valid_o,
   output logic                                    video_18bit_o,
   // Audio path
   input  wire logic                               inband_chb_valid_i,
   input  wire logic                               inband_chb_en_i,
   output logic                                    audio_packet_en_o,
   output logic                                    i2s_regen_o,
   output logic                                    i2s_frame_xport_o,
   output logic                                    second_chan_en_o,
   // Straps
   input  wire logic [ppd_pkg::STRAP_LVL_W-1:0]    config_strap_a_i,
   input  wire logic [ppd_pkg::STRAP_LVL_W-1:0]    config_strap_b_i
);

   if (PIX_W != 24) begin : g_chk
      $error("PIX_W must be 24: three 8-bit colours");
   end

   // ==========================================================
   // Helpers
   // ==========================================================
   function automatic logic [ppd_pkg::ADDR_W-1:0] byte_addr(
      input logic [ppd_pkg::IDX_W-1:0] idx
   );
      byte_addr = {idx, 2'b00};
   endfunction

   function automatic logic drives_pin(input logic [1:0] mode);
      drives_pin = (ppd_pkg::ppd_pin_mode_t'(mode) == ppd_pkg::PIN_GP_OUT);
   endfunction

   // ==========================================================
   // Registers
   // ==========================================================
   logic [ppd_pkg::REG_W-1:0]        spare_pin_pair_config;
   logic [ppd_pkg::REG_W-1:0]        video_audio_path_control;
   logic [ppd_pkg::REG_W-1:0]        strap_level_status;
   logic [1:0]                       spare_pin_level;

   // ==========================================================
   // Bus decode
   // ==========================================================
   wire req         = avs_read_i | avs_write_i;
   wire accept      = req & ~avs_waitrequest_o;
   wire hit_spare   = (avs_address_i == byte_addr(ppd_pkg::IDX_SPARE));
   wire hit_path    = (avs_address_i == byte_addr(ppd_pkg::IDX_PATH));
   wire hit_strap   = (avs_address_i == byte_addr(ppd_pkg::IDX_STRAP));
   wire hit_level   = (avs_address_i == byte_addr(ppd_pkg::IDX_LEVEL));
   wire mapped      = hit_spare | hit_path | hit_strap | hit_level;
   wire lane0_wr    = accept & avs_write_i & avs_byteenable_i[0];
   wire wr_spare    = lane0_wr & hit_spare;
   wire wr_path     = lane0_wr & hit_path;
   wire [ppd_pkg::REG_W-1:0] wdata = avs_writedata_i[ppd_pkg::REG_W-1:0];

   wire [ppd_pkg::REG_W-1:0] rd_byte =
      hit_spare ? spare_pin_pair_config :
      hit_path  ? video_audio_path_control :
      hit_strap ? strap_level_status :
      hit_level ? {6'h00, spare_pin_level} :
                  8'h00;

   wire [ppd_pkg::DATA_W-1:0] next_readdata =
      (avs_read_i && mapped) ? {24'h00_0000, rd_byte} : 32'h0000_0000;

   // One wait cycle: first edge of a request drops waitrequest and loads data
   always_ff @(posedge clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         avs_waitrequest_o <= 1'b1;
         avs_readdata_o    <= 32'h0000_0000;
         avs_response_o    <= ppd_pkg::RESP_OKAY;
      end else begin
         avs_waitrequest_o <= ~(req & avs_waitrequest_o);
         if (req && avs_waitrequest_o) begin
            avs_readdata_o <= next_readdata;
            avs_response_o <= mapped ? ppd_pkg::RESP_OKAY : ppd_pkg::RESP_DECODE;
         end
      end
   end

   // ==========================================================
   // Writable registers
   // ==========================================================
   always_ff @(posedge clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         spare_pin_pair_config <= ppd_pkg::SPARE_RST;
      end else if (wr_spare) begin
         spare_pin_pair_config <= wdata & ppd_pkg::SPARE_WMASK;
      end
   end

   always_ff @(posedge clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         video_audio_path_control <= ppd_pkg::PATH_RST;
      end else if (wr_path) begin
         video_audio_path_control <= wdata & ppd_pkg::PATH_WMASK;
      end
   end

   // ==========================================================
   // Spare pins
   // ==========================================================
   wire [1:0] pin_mode [2];
   wire [1:0] pin_value;
   wire [1:0] pin_level;
   logic [1:0] pin_out;
   logic [1:0] pin_oe_n;
   logic [1:0] pin_func;

   assign pin_mode[0]  = spare_pin_pair_config[ppd_pkg::SEVEN_MODE_LSB +: 2];
   assign pin_mode[1]  = spare_pin_pair_config[ppd_pkg::EIGHT_MODE_LSB +: 2];
   assign pin_value[0] = spare_pin_pair_config[ppd_pkg::SEVEN_OUT_BIT];
   assign pin_value[1] = spare_pin_pair_config[ppd_pkg::EIGHT_OUT_BIT];
   assign pin_level[0] = spare_io_seven_i;
   assign pin_level[1] = spare_io_eight_i;

   for (genvar p = 0; p < 2; p++) begin : g_pin
      wire next_oe_n = ~drives_pin(pin_mode[p]);
      wire next_out  = drives_pin(pin_mode[p]) & pin_value[p];
      wire next_func = (pin_mode[p] == ppd_pkg::PIN_FUNC_IN) & pin_level[p];

      always_ff @(posedge clk_i or negedge nrst_i) begin
         if (!nrst_i) begin
            pin_oe_n[p] <= 1'b1;
            pin_out[p]  <= 1'b0;
            pin_func[p] <= 1'b0;
         end else begin
            pin_oe_n[p] <= next_oe_n;
            pin_out[p]  <= next_out;
            pin_func[p] <= next_func;
         end
      end

      // Input level is only updated in general-purpose input mode
      always_ff @(posedge clk_i or negedge nrst_i) begin
         if (!nrst_i) begin
            spare_pin_level[p] <= 1'b0;
         end else if (pin_mode[p] == ppd_pkg::PIN_GP_IN) begin
            spare_pin_level[p] <= pin_level[p];
         end
      end
   end

   assign spare_io_seven_o      = pin_out[0];
   assign spare_io_seven_oe_n_o = pin_oe_n[0];
   assign spare_io_seven_func_o = pin_func[0];
   assign spare_io_eight_o      = pin_out[1];
   assign spare_io_eight_oe_n_o = pin_oe_n[1];
   assign spare_io_eight_func_o = pin_func[1];

   // ==========================================================
   // Video path
   // ==========================================================
   wire bypass    = video_audio_path_control[ppd_pkg::PATH_BYPASS];
   wire de_inv    = video_audio_path_control[ppd_pkg::PATH_DE_POL];
   wire depth18   = video_audio_path_control[ppd_pkg::PATH_DEPTH18];
   wire active    = video_active_flag_i ^ de_inv;
   wire forward   = bypass | active;

   // 18-bit mode keeps six bits per colour, the low two are cleared
   wire [PIX_W-1:0] depth_mask = depth18 ? 24'hFC_FCFC : 24'hFF_FFFF;
   wire [PIX_W-1:0] next_rgb   = forward ? (rgb_i & depth_mask) : 24'h00_0000;

   always_ff @(posedge clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         rgb_o         <= 24'h00_0000;
         pixel_valid_o <= 1'b0;
         video_18bit_o <= 1'b0;
      end else begin
         rgb_o         <= next_rgb;
         pixel_valid_o <= forward;
         video_18bit_o <= depth18;
      end
   end

   // ==========================================================
   // Audio path
   // ==========================================================
   wire chb_ovr     = video_audio_path_control[ppd_pkg::PATH_CHB_OVR];
   wire chb_bit     = video_audio_path_control[ppd_pkg::PATH_CHB_EN];
   wire detector_on = inband_chb_valid_i & ~chb_ovr;
   wire next_chb    = detector_on ? inband_chb_en_i : chb_bit;

   always_ff @(posedge clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         audio_packet_en_o <= 1'b1;
         i2s_regen_o       <= 1'b0;
         i2s_frame_xport_o <= 1'b0;
         second_chan_en_o  <= 1'b0;
      end else begin
         audio_packet_en_o <= ~bypass;
         i2s_regen_o       <= video_audio_path_control[ppd_pkg::PATH_REGEN];
         i2s_frame_xport_o <= video_audio_path_control[ppd_pkg::PATH_FC_XPORT];
         second_chan_en_o  <= next_chb;
      end
   end

   // ==========================================================
   // Strap status
   // ==========================================================
   logic [ppd_pkg::STRAP_LVL_W-1:0] strap_a_level;
   logic [ppd_pkg::STRAP_LVL_W-1:0] strap_b_level;
   logic                            strap_a_done;
   logic                            strap_b_done;

   ppd_strap_capture #(
      .SETTLE_CYC (SETTLE_CYC)
   ) u_strap_a (
      .clk_i   (clk_i),
      .nrst_i  (nrst_i),
      .level_i (config_strap_a_i),
      .level_o (strap_a_level),
      .done_o  (strap_a_done)
   );

   ppd_strap_capture #(
      .SETTLE_CYC (SETTLE_CYC)
   ) u_strap_b (
      .clk_i   (clk_i),
      .nrst_i  (nrst_i),
      .level_i (config_strap_b_i),
      .level_o (strap_b_level),
      .done_o  (strap_b_done)
   );

   always_comb begin
      strap_level_status = '0;
      strap_level_status[ppd_pkg::STRAP_B_DONE] = strap_b_done;
      strap_level_status[ppd_pkg::STRAP_B_LSB +: ppd_pkg::STRAP_LVL_W] = strap_b_level;
      strap_level_status[ppd_pkg::STRAP_A_DONE] = strap_a_done;
      strap_level_status[ppd_pkg::STRAP_A_LSB +: ppd_pkg::STRAP_LVL_W] = strap_a_level;
   end

endmodule // ppd_regs

/* core/ppd_pkg.sv */
// Package for the pin pair, data path and strap register bank.
// Assumes a single 20 MHz clock and an Avalon-MM slave with byte addressing.
package ppd_pkg;

   // ==========================================================
   // Bus geometry and answers
   // ==========================================================
   localparam int          ADDR_W       = 8;
   localparam int          DATA_W       = 32;
   localparam int          REG_W        = 8;
   localparam int          IDX_W        = 6;
   localparam logic [1:0]  RESP_OKAY    = 2'h0;
   localparam logic [1:0]  RESP_DECODE  = 2'h3;

   // ==========================================================
   // Register indices (byte address is four times the index)
   // ==========================================================
   localparam logic [IDX_W-1:0] IDX_SPARE = 6'h11;
   localparam logic [IDX_W-1:0] IDX_PATH  = 6'h12;
   localparam logic [IDX_W-1:0] IDX_STRAP = 6'h13;
   localparam logic [IDX_W-1:0] IDX_LEVEL = 6'h20;

   // ==========================================================
   // Reset values and writable masks
   // ==========================================================
   localparam logic [REG_W-1:0] SPARE_RST   = 8'h00;
   localparam logic [REG_W-1:0] PATH_RST    = 8'h00;
   localparam logic [REG_W-1:0] STRAP_RST   = 8'h88;
   localparam logic [REG_W-1:0] SPARE_WMASK = 8'hBB;
   localparam logic [REG_W-1:0] PATH_WMASK  = 8'h7F;

   // ==========================================================
   // Field positions
   // ==========================================================
   localparam int SEVEN_MODE_LSB = 0;
   localparam int SEVEN_OUT_BIT  = 3;
   localparam int EIGHT_MODE_LSB = 4;
   localparam int EIGHT_OUT_BIT  = 7;
   localparam int PATH_BYPASS    = 6;
   localparam int PATH_DE_POL    = 5;
   localparam int PATH_REGEN     = 4;
   localparam int PATH_CHB_OVR   = 3;
   localparam int PATH_DEPTH18   = 2;
   localparam int PATH_FC_XPORT  = 1;
   localparam int PATH_CHB_EN    = 0;
   localparam int STRAP_A_LSB    = 0;
   localparam int STRAP_A_DONE   = 3;
   localparam int STRAP_B_LSB    = 4;
   localparam int STRAP_B_DONE   = 7;
   localparam int STRAP_LVL_W    = 3;

   // ==========================================================
   // Pin modes
   // ==========================================================
   typedef enum logic [1:0] {
      PIN_FUNC_IN = 2'b00,
      PIN_GP_OUT  = 2'b01,
      PIN_HIZ     = 2'b10,
      PIN_GP_IN   = 2'b11
   } ppd_pin_mode_t;

   // ==========================================================
   // Timing
   // ==========================================================
   localparam int CLK_PERIOD_NS    = 50;
   localparam int STRAP_SETTLE_NS  = 1000;
   localparam int STRAP_SETTLE_CYC = (STRAP_SETTLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

endpackage

/* core/ppd_strap_capture.sv */
// Settle-and-latch capture of one multi-level strap pin.
// Assumes the pad comparator delivers a decoded level synchronous to clk_i.
`timescale 1ns/1ps

module ppd_strap_capture #(
   parameter int SETTLE_CYC = ppd_pkg::STRAP_SETTLE_CYC
) (
   input  wire logic                              clk_i,
   input  wire logic                              nrst_i,
   input  wire logic [ppd_pkg::STRAP_LVL_W-1:0]   level_i,
   output logic      [ppd_pkg::STRAP_LVL_W-1:0]   level_o,
   output logic                                   done_o
);

   if (SETTLE_CYC < 1 || SETTLE_CYC > 65535) begin : g_chk
      $error("SETTLE_CYC out of range");
   end

   // ==========================================================
   // State
   // ==========================================================
   typedef enum logic [2:0] {
      CAP_RESET  = 3'b001,
      CAP_SETTLE = 3'b010,
      CAP_LOCKED = 3'b100
   } ppd_cap_state_t;

   ppd_cap_state_t                     state;
   ppd_cap_state_t                     next_state;
   logic [15:0]                        stable_cnt;
   logic [ppd_pkg::STRAP_LVL_W-1:0]    last_level;

   wire same_level = (level_i == last_level);
   wire settled    = same_level && (stable_cnt == 16'(SETTLE_CYC - 1));

   always_comb begin
      next_state = state;
      unique case (state)
         CAP_RESET:  next_state = CAP_SETTLE;
         CAP_SETTLE: if (settled) begin
            next_state = CAP_LOCKED;
         end
         CAP_LOCKED: next_state = CAP_LOCKED;
         default:    next_state = CAP_RESET;
      endcase
   end

   always_ff @(posedge clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         state <= CAP_RESET;
      end else begin
         state <= next_state;
      end
   end

   // Level must hold unchanged for the whole settle window
   always_ff @(posedge clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         stable_cnt <= 16'h0000;
         last_level <= '0;
      end else begin
         last_level <= level_i;
         if (state != CAP_SETTLE || !same_level) begin
            stable_cnt <= 16'h0000;
         end else if (!settled) begin
            stable_cnt <= stable_cnt + 16'h0001;
         end
      end
   end

   // Latch once; done reads high at reset and again after the latch
   always_ff @(posedge clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         level_o <= '0;
         done_o  <= 1'b1;
      end else begin
         if (state == CAP_SETTLE && settled) begin
            level_o <= last_level;
         end
         done_o <= (next_state != CAP_SETTLE);
      end
   end

endmodule // ppd_strap_capture

/* tb/ppd_regs_checker.sv */
// Concurrent checks for the ppd_regs register bank.
// Assumes it is bound to ppd_regs and sees only that module's ports.
`timescale 1ns/1ps

module ppd_regs_checker #(
   parameter int PIX_W = 24
) (
   input wire logic              clk_i,
   input wire logic              nrst_i,
   input wire logic [7:0]        avs_address_i,
   input wire logic              avs_read_i,
   input wire logic              avs_write_i,
   input wire logic [31:0]       avs_writedata_i,
   input wire logic [3:0]        avs_byteenable_i,
   input wire logic [31:0]       avs_readdata_o,
   input wire logic [1:0]        avs_response_o,
   input wire logic              avs_waitrequest_o,
   input wire logic              spare_io_seven_o,
   input wire logic              spare_io_seven_oe_n_o,
   input wire logic              spare_io_eight_o,
   input wire logic              spare_io_eight_oe_n_o,
   input wire logic [PIX_W-1:0]  rgb_i,
   input wire logic [PIX_W-1:0]  rgb_o,
   input wire logic              pixel_valid_o,
   input wire logic              video_18bit_o,
   input wire logic              audio_packet_en_o,
   input wire logic              second_chan_en_o,
   input wire logic [2:0]        config_strap_a_i,
   input wire logic [2:0]        config_strap_b_i
);
   // ==========================================
   // Helper decode
   // ==========================================
   logic [7:0] last_wd;
   wire commit = avs_write_i && !avs_waitrequest_o;
   wire rd     = avs_read_i && !avs_waitrequest_o;
   wire wr44   = commit && avs_address_i == 8'h44 && avs_byteenable_i[0];
   wire wr48   = commit && avs_address_i == 8'h48 && avs_byteenable_i[0];
   wire mapped = avs_address_i inside {8'h44, 8'h48, 8'h4C, 8'h80};
   wire rd4c   = rd && avs_address_i == 8'h4C;

   // Last committed byte
   always_ff @(posedge clk_i or negedge nrst_i) begin
      if (!nrst_i) last_wd <= 8'h00;
      else if (commit) last_wd <= avs_writedata_i[7:0];
   end

   default clocking cb @(posedge clk_i); endclocking
   default disable iff (!nrst_i);

   // ==========================================
   // Properties
   // ==========================================
   property p_seven;
      wr44 |-> ##2 (spare_io_seven_oe_n_o == (last_wd[1:0] != 2'b01))
         && (spare_io_seven_o == (last_wd[1:0] == 2'b01 && last_wd[3]));
   endproperty
   property p_eight;
      wr44 |-> ##2 (spare_io_eight_oe_n_o == (last_wd[5:4] != 2'b01))
         && (spare_io_eight_o == (last_wd[5:4] == 2'b01 && last_wd[7]));
   endproperty
   property p_pin_idle;
      !(spare_io_seven_oe_n_o && spare_io_seven_o) && !(spare_io_eight_oe_n_o && spare_io_eight_o);
   endproperty
   property p_path;
      wr48 |-> ##2 video_18bit_o == last_wd[2] && audio_packet_en_o == !last_wd[6];
   endproperty
   property p_chb;
      wr48 && avs_writedata_i[3] |-> ##2 second_chan_en_o == last_wd[0];
   endproperty
   property p_bypass;
      (!audio_packet_en_o && !video_18bit_o) |-> pixel_valid_o && rgb_o == $past(rgb_i);
   endproperty
   property p_answer;
      ((avs_read_i || avs_write_i) && avs_waitrequest_o) |=> !avs_waitrequest_o ##1 avs_waitrequest_o;
   endproperty
   property p_rsvd;
      rd |-> !(avs_address_i == 8'h44 && |(avs_readdata_o & 32'hFFFF_FF44))
         && !(avs_address_i == 8'h48 && |(avs_readdata_o & 32'hFFFF_FF80))
         && (mapped || (avs_response_o == 2'h3 && avs_readdata_o == 32'h0000_0000));
   endproperty
   property p_strap_b;
      rd4c && avs_readdata_o[7] |-> avs_readdata_o[6:4] == config_strap_b_i;
   endproperty
   property p_strap_a;
      rd4c && avs_readdata_o[3] |-> avs_readdata_o[2:0] == config_strap_a_i;
   endproperty

   a_seven: assert property (p_seven) else $error("spare seven pin wrong");
   a_eight: assert property (p_eight) else $error("spare eight pin wrong");
   a_pin_idle: assert property (p_pin_idle) else $error("undriven pin value");
   a_path: assert property (p_path) else $error("path outputs wrong");
   a_chb: assert property (p_chb) else $error("second channel wrong");
   a_bypass: assert property (p_bypass) else $error("bypass not forwarding");
   a_answer: assert property (p_answer) else $error("bus answer timing");
   a_rsvd: assert property (p_rsvd) else $error("reserved or unmapped data");
   a_strap_b: assert property (p_strap_b) else $error("strap b level");
   a_strap_a: assert property (p_strap_a) else $error("strap a level");

   c_spare: cover property (wr44);
   c_bypass: cover property (wr48 && avs_writedata_i[6]);
   c_unmapped: cover property (rd && !mapped);
endmodule // ppd_regs_checker

bind ppd_regs ppd_regs_checker #(.PIX_W(PIX_W)) i_ppd_regs_checker (
   .clk_i(clk_i), .nrst_i(nrst_i), .avs_address_i(avs_address_i), .avs_read_i(avs_read_i),
   .avs_write_i(avs_write_i), .avs_writedata_i(avs_writedata_i),
   .avs_byteenable_i(avs_byteenable_i), .avs_readdata_o(avs_readdata_o),
   .avs_response_o(avs_response_o), .avs_waitrequest_o(avs_waitrequest_o),
   .spare_io_seven_o(spare_io_seven_o), .spare_io_seven_oe_n_o(spare_io_seven_oe_n_o),
   .spare_io_eight_o(spare_io_eight_o), .spare_io_eight_oe_n_o(spare_io_eight_oe_n_o),
   .rgb_i(rgb_i), .rgb_o(rgb_o), .pixel_valid_o(pixel_valid_o), .video_18bit_o(video_18bit_o),
   .audio_packet_en_o(audio_packet_en_o), .second_chan_en_o(second_chan_en_o),
   .config_strap_a_i(config_strap_a_i), .config_strap_b_i(config_strap_b_i));

/* tb/testbench.sv */
// Self-checking bench for the ppd_regs register bank.
// Assumes ppd_regs with a short strap settle count and a 20 MHz clock.
`timescale 1ns/1ps

module testbench;
   logic         clk_i = 1'b0;
   logic         nrst_i = 1'b0;
   logic [7:0]   adr = 8'h00;
   logic         rd = 1'b0;
   logic         wr = 1'b0;
   logic [31:0]  wd = 32'h0000_0000;
   logic [3:0]   be = 4'h1;
   logic [31:0]  rdata;
   logic [1:0]   resp;
   logic         wreq;
   logic         s7_i = 1'b1, s7_o, s7_oe_n, s7_fn, s8_i = 1'b0, s8_o, s8_oe_n, s8_fn;
   logic [23:0]  rgb = 24'hA5_5AC3;
   logic [23:0]  rgb_o;
   logic         flag = 1'b0, pixv, v18, iv = 1'b0, ie = 1'b0, ape, regen, xport, chb;
   logic [2:0]   sa = 3'h5, sb = 3'h3;
   int           num_errors = 0;
   int           samples_checked = 0;

   always #25 clk_i = ~clk_i;

   ppd_regs #(.PIX_W(24), .SETTLE_CYC(2)) i_ppd_regs (
      .clk_i(clk_i), .nrst_i(nrst_i), .avs_address_i(adr), .avs_read_i(rd), .avs_write_i(wr),
      .avs_writedata_i(wd), .avs_byteenable_i(be), .avs_readdata_o(rdata),
      .avs_response_o(resp), .avs_waitrequest_o(wreq), .spare_io_seven_i(s7_i),
      .spare_io_seven_o(s7_o), .spare_io_seven_oe_n_o(s7_oe_n), .spare_io_seven_func_o(s7_fn),
      .spare_io_eight_i(s8_i), .spare_io_eight_o(s8_o), .spare_io_eight_oe_n_o(s8_oe_n),
      .spare_io_eight_func_o(s8_fn), .rgb_i(rgb), .video_active_flag_i(flag), .rgb_o(rgb_o),
      .pixel_valid_o(pixv), .video_18bit_o(v18), .inband_chb_valid_i(iv), .inband_chb_en_i(ie),
      .audio_packet_en_o(ape), .i2s_regen_o(regen), .i2s_frame_xport_o(xport),
      .second_chan_en_o(chb), .config_strap_a_i(sa), .config_strap_b_i(sb));

   // ==========================================
   // Checking and bus tasks
   // ==========================================
   task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         num_errors++;
         $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
      end
   endtask

   task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d,
                      input logic [3:0] b, output logic [31:0] q, output logic [1:0] r);
      int n;
      @(posedge clk_i);
      adr <= a;
      wd <= d;
      be <= b;
      wr <= w;
      rd <= !w;
      n = 0;
      do begin
         @(posedge clk_i);
         n++;
      end while (wreq !== 1'b0 && n < 40);
      if (n >= 40) num_errors++;
      q = rdata;
      r = resp;
      wr <= 1'b0;
      rd <= 1'b0;
   endtask

   task automatic rd_chk(input string nm, input logic [7:0] a, input logic [31:0] e,
                         input logic [1:0] er);
      logic [31:0] q;
      logic [1:0]  r;
      bus(1'b0, a, 32'h0000_0000, 4'hF, q, r);
      check(nm, q, e);
      check({nm, "_resp"}, r, er);
   endtask

   task automatic reset_cycle();
      nrst_i <= 1'b0;
      repeat (16) @(posedge clk_i);
      check("rst_wait", wreq, 1);
      check("rst_pins", {s7_oe_n, s8_oe_n, s7_o, s8_o}, 4'hC);
      check("rst_audio", ape, 1);
      nrst_i <= 1'b1;
      repeat (30) @(posedge clk_i);
   endtask

   task automatic test_done();
      $display("checks %0d mismatches %0d", samples_checked, num_errors);
      if (num_errors == 0 && samples_checked > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
   endtask

   initial begin
      repeat (20000) @(posedge clk_i);
      num_errors++;
      test_done();
   end

   // ==========================================
   // Main sequence
   // ==========================================
   initial begin
      logic [31:0] q;
      logic [1:0]  r;
      logic [7:0]  d;
      logic        pv, o;
      reset_cycle();
      rd_chk("strap", 8'h4C, 32'h0000_00BD, 2'h0);
      rd_chk("spare_rst", 8'h44, 32'h0000_0000, 2'h0);
      rd_chk("path_rst", 8'h48, 32'h0000_0000, 2'h0);
      for (int i = 0; i < 8; i++) begin
         d = {i[2], 1'b1, i[1:0], i[2], 1'b1, i[1:0]};
         o = i[1:0] == 2'b01;
         s8_i <= i[2];
         bus(1'b1, 8'h44, {24'h00_0000, d}, 4'h1, q, r);
         repeat (2) @(posedge clk_i);
         check("s7_oe", s7_oe_n, !o);
         check("s8_oe", s8_oe_n, !o);
         check("s7_out", s7_o, o & i[2]);
         check("s8_out", s8_o, o & i[2]);
         check("func", {s7_fn, s8_fn}, {2{i[1:0] == 2'b00}} & {1'b1, i[2]});
         rd_chk("spare_rb", 8'h44, {24'h00_0000, d & 8'hBB}, 2'h0);
         if (&i[1:0]) rd_chk("level", 8'h80, {24'h00_0000, 6'h00, i[2], 1'b1}, 2'h0);
      end
      bus(1'b1, 8'h44, 32'h0000_0000, 4'hE, q, r);
      rd_chk("be_off", 8'h44, 32'h0000_00BB, 2'h0);
      rd_chk("unmapped", 8'h00, 32'h0000_0000, 2'h3);
      rd_chk("unaligned", 8'h45, 32'h0000_0000, 2'h3);
      bus(1'b1, 8'h4C, 32'h0000_0000, 4'h1, q, r);
      rd_chk("strap_ro", 8'h4C, 32'h0000_00BD, 2'h0);
      for (int i = 0; i < 256; i++) begin
         d = i[7:0];
         flag <= i[1] ^ i[5];
         iv <= i[7];
         ie <= i[6] ^ i[0];
         bus(1'b1, 8'h48, {24'h00_0000, d}, 4'h1, q, r);
         repeat (2) @(posedge clk_i);
         pv = d[6] | (i[1] ^ i[5] ^ d[5]);
         check("pix_valid", pixv, pv);
         check("rgb", rgb_o, pv ? (d[2] ? rgb & 24'hFC_FCFC : rgb) : 24'h00_0000);
         check("depth", v18, d[2]);
         check("audio_pkt", ape, !d[6]);
         check("regen", regen, d[4]);
         check("xport", xport, d[1]);
         check("chan_b", chb, d[3] ? d[0] : (i[7] ? i[6] ^ i[0] : d[0]));
         if (i[3:0] == 4'hF) rd_chk("path_rb", 8'h48, {24'h00_0000, d & 8'h7F}, 2'h0);
      end
      sa <= 3'h2;
      sb <= 3'h6;
      reset_cycle();
      rd_chk("strap2", 8'h4C, 32'h0000_00EA, 2'h0);
      rd_chk("spare_rst2", 8'h44, 32'h0000_0000, 2'h0);
      test_done();
   end
endmodule // testbench
